//--- pkg/apg_pkg.sv
// package: constants and types for the aux pointer address generator
package apg_pkg;
    localparam int ADDR_W = 23;
    localparam int LOW_W = 16;
    localparam int HIGH_W = 7;
    localparam int DATA_W = 16;
    localparam int K16_W = 16;
    localparam int EXT_BYTES = 2;
    localparam logic [22:0] PTR_RESET = 23'h00_0000;
    localparam logic [22:0] ADDR_ONE = 23'h00_0001;
    localparam logic [15:0] DATA_RESET = 16'h0000;

    // operand forms handled here
    typedef enum logic [1:0]
    {
        APG_MODE_POSTDEC = 2'h0,
        APG_MODE_INDEX = 2'h1,
        APG_MODE_CONST = 2'h2,
        APG_MODE_NONE = 2'h3
    } apg_mode_t;

    typedef enum logic [2:0]
    {
        APG_ST_IDLE = 3'b001,
        APG_ST_FIRST = 3'b010,
        APG_ST_SECOND = 3'b100
    } apg_state_t;
endpackage

//--- verilog/apg_top.sv
// aux pointer address generator for three indirect operand forms
`timescale 1ns/10ps
// Operation
// - post-decrement: access at pointer, then subtract temp
// - indexed: address pointer plus temp, pointer kept
// - constant: sign-extended offset plus pointer, kept
// - offset taken from two-byte instruction extension
// - constant-offset instruction never paired in parallel
// - double word: address, then plus/minus one by parity
// - first word to named register, second next
// - circular: zero-extended buffer start added to address
module apg_top
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic req_valid_in,
    input wire apg_pkg::apg_mode_t mode_in,
    input wire logic dbl_in,
    input wire logic [22:0] ptr_load_in,
    input wire logic ptr_load_en_in,
    input wire logic [15:0] temp_reg_one_in,
    input wire logic [15:0] circ_buffer_start_in,
    input wire logic circ_enable_in,
    input wire logic [7:0] ext_byte_hi_in,
    input wire logic [7:0] ext_byte_lo_in,
    input wire logic mem_ready_in,
    input wire logic [15:0] mem_rdata_in,
    output logic busy_out,
    output logic parallel_ok_out,
    output logic mem_req_out,
    output logic [22:0] mem_addr_out,
    output logic [22:0] ext_aux_pointer_out,
    output logic [15:0] pair_first_out,
    output logic [15:0] pair_second_out,
    output logic done_out
);
    // ------------------------------------------------------------
    // address formation
    // ------------------------------------------------------------
    logic [22:0] ptr_q;
    logic [22:0] ptr_d;
    apg_pkg::apg_state_t state_q;
    apg_pkg::apg_state_t state_d;
    logic [22:0] addr_q;
    logic [22:0] addr_d;
    logic dbl_q;
    logic dbl_d;
    logic [15:0] first_q;
    logic [15:0] first_d;
    logic [15:0] second_q;
    logic [15:0] second_d;
    logic done_q;
    logic done_d;
    logic [15:0] long_signed_offset;
    logic [22:0] offset_ext;
    logic [22:0] temp_ext;
    logic [22:0] base_addr;
    logic [22:0] pair_addr;
    logic [22:0] new_ptr;
    logic take;

    assign long_signed_offset = {ext_byte_hi_in, ext_byte_lo_in};
    assign offset_ext = {{(apg_pkg::ADDR_W - apg_pkg::K16_W)
        {long_signed_offset[15]}}, long_signed_offset};
    assign temp_ext = {{(apg_pkg::ADDR_W - apg_pkg::DATA_W){1'b0}},
        temp_reg_one_in};
    assign parallel_ok_out = (mode_in != apg_pkg::APG_MODE_CONST);
    assign take = req_valid_in && (state_q == apg_pkg::APG_ST_IDLE)
        && (mode_in != apg_pkg::APG_MODE_NONE);

    always_comb
    begin
        base_addr = ptr_q;
        new_ptr = ptr_q;
        case (mode_in)
            apg_pkg::APG_MODE_POSTDEC:
            begin
                base_addr = ptr_q;
                new_ptr = 23'(ptr_q - temp_ext);
            end
            apg_pkg::APG_MODE_INDEX:
                base_addr = 23'(ptr_q + temp_ext);
            apg_pkg::APG_MODE_CONST:
                base_addr = 23'(ptr_q + offset_ext);
            default:
                base_addr = ptr_q;
        endcase
        if (circ_enable_in)
        begin
            base_addr = 23'(base_addr + {{(apg_pkg::ADDR_W
                - apg_pkg::DATA_W){1'b0}}, circ_buffer_start_in});
        end
    end

    assign pair_addr = addr_q[0] ? 23'(addr_q - apg_pkg::ADDR_ONE)
        : 23'(addr_q + apg_pkg::ADDR_ONE);

    // ------------------------------------------------------------
    // access sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        ptr_d = ptr_q;
        addr_d = addr_q;
        dbl_d = dbl_q;
        first_d = first_q;
        second_d = second_q;
        done_d = 1'b0;
        case (state_q)
            apg_pkg::APG_ST_IDLE:
            begin
                if (ptr_load_en_in)
                begin
                    ptr_d = ptr_load_in;
                end
                if (take)
                begin
                    addr_d = base_addr;
                    dbl_d = dbl_in;
                    ptr_d = new_ptr;
                    state_d = apg_pkg::APG_ST_FIRST;
                end
            end
            apg_pkg::APG_ST_FIRST:
            begin
                if (mem_ready_in)
                begin
                    first_d = mem_rdata_in;
                    if (dbl_q)
                    begin
                        addr_d = pair_addr;
                        state_d = apg_pkg::APG_ST_SECOND;
                    end
                    else
                    begin
                        done_d = 1'b1;
                        state_d = apg_pkg::APG_ST_IDLE;
                    end
                end
            end
            apg_pkg::APG_ST_SECOND:
            begin
                if (mem_ready_in)
                begin
                    second_d = mem_rdata_in;
                    done_d = 1'b1;
                    state_d = apg_pkg::APG_ST_IDLE;
                end
            end
            default:
                state_d = apg_pkg::APG_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_q <= apg_pkg::APG_ST_IDLE;
            ptr_q <= apg_pkg::PTR_RESET;
            addr_q <= apg_pkg::PTR_RESET;
            dbl_q <= 1'b0;
            first_q <= apg_pkg::DATA_RESET;
            second_q <= apg_pkg::DATA_RESET;
            done_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            ptr_q <= ptr_d;
            addr_q <= addr_d;
            dbl_q <= dbl_d;
            first_q <= first_d;
            second_q <= second_d;
            done_q <= done_d;
        end
    end

    assign busy_out = (state_q != apg_pkg::APG_ST_IDLE);
    assign mem_req_out = busy_out;
    assign mem_addr_out = addr_q;
    assign ext_aux_pointer_out = ptr_q;
    assign pair_first_out = first_q;
    assign pair_second_out = second_q;
    assign done_out = done_q;
endmodule

//--- dv/apg_props.sv
// checker: handshake and address order at the apg_top ports
`timescale 1ns/10ps
module apg_props
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic req_valid_in,
    input wire apg_pkg::apg_mode_t mode_in,
    input wire logic mem_ready_in,
    input wire logic busy_out,
    input wire logic parallel_ok_out,
    input wire logic mem_req_out,
    input wire logic [22:0] mem_addr_out,
    input wire logic done_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    sequence take_s; req_valid_in && !busy_out && mode_in != 2'h3; endsequence
    sequence acc_s; mem_req_out && mem_ready_in; endsequence
    AST_TAKE: assert property (take_s |=> mem_req_out)
        else $error("request not taken");
    AST_PAR: assert property (parallel_ok_out == (mode_in != 2'h2))
        else $error("parallel flag wrong");
    AST_IDLE: assert property (!busy_out && mode_in == 2'h3 |=> !busy_out)
        else $error("unused form started");
    AST_HOLD: assert property (mem_req_out && !mem_ready_in |=>
        mem_req_out && $stable(mem_addr_out)) else $error("address moved");
    AST_PAIR: assert property (acc_s ##1 mem_req_out |->
        mem_addr_out == ($past(mem_addr_out) ^ 23'h00_0001))
        else $error("second address wrong");
    AST_DONE: assert property (acc_s ##1 !mem_req_out |-> done_out)
        else $error("no done");
    AST_PULSE: assert property (done_out |=> !done_out)
        else $error("done too long");
    AST_CAUSE: assert property (done_out |-> $past(mem_req_out && mem_ready_in))
        else $error("done without access");
endmodule
bind apg_top apg_props i_props (.*);

//--- dv/apg_mem.sv
// partner: memory returning the low address bits, sometimes late
`timescale 1ns/10ps
module apg_mem
(
    input wire logic clk_sys_in,
    input wire logic req_in,
    input wire logic slow_in,
    input wire logic [22:0] addr_in,
    output logic rdy_out,
    output logic [15:0] data_out
);
    logic rdy_q = 1'b0;
    logic [15:0] junk_q = 16'h0000;
    always @(posedge clk_sys_in)
    begin
        junk_q <= junk_q + 16'h3c5b;
        rdy_q <= req_in && !rdy_q && !(slow_in && junk_q[0]);
    end
    assign rdy_out = rdy_q;
    // junk off the beat so stale data never matches
    assign data_out = rdy_q ? addr_in[15:0] : junk_q;
endmodule

//--- dv/tb.sv
// bench: random operand forms against the memory model
`timescale 1ns/10ps
module tb;
    logic clk_sys_in = 1'b0, rst_n_in = 1'b0, req_valid_in = 1'b0;
    logic dbl_in = 1'b0, ptr_load_en_in = 1'b0, circ_enable_in = 1'b0;
    logic slow = 1'b0, mem_ready_in, busy_out, mem_req_out, done_out;
    apg_pkg::apg_mode_t mode_in = apg_pkg::APG_MODE_NONE;
    logic [22:0] ptr_load_in = 23'h00_0000, mem_addr_out, ext_aux_pointer_out;
    logic [15:0] temp_reg_one_in = 16'h0000, circ_buffer_start_in = 16'h0000;
    logic [15:0] k = 16'h0000, r = 16'h0001, mem_rdata_in;
    logic [15:0] pair_first_out, pair_second_out;
    logic [55:0] exp_q[$], e;
    int miscompares = 0, samples_checked = 0;
    always #20 clk_sys_in = ~clk_sys_in;
    apg_top i_dut (.*, .ext_byte_hi_in(k[15:8]), .ext_byte_lo_in(k[7:0]),
        .parallel_ok_out());
    apg_mem i_mem (.clk_sys_in, .req_in(mem_req_out), .slow_in(slow),
        .addr_in(mem_addr_out), .rdy_out(mem_ready_in),
        .data_out(mem_rdata_in));
    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [22:0] seen, input logic [22:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h want %h", $time, seen, want);
        end
    endtask
    task automatic test_done;
        $display("checked %0d failed %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic go(input logic [1:0] m, input logic [22:0] p);
        logic [22:0] a, q;
        begin
            r = nx(r);
            a = m == 2'h0 ? p : m == 2'h1 ? p + {7'h00, ~r}
                : p + {{7{r[15]}}, r};
            if (r[3])
                a = a + {7'h00, r[7:0], r[15:8]};
            q = m == 2'h0 ? p - {7'h00, ~r} : p;
            exp_q.push_back({r[0], a[15:0], a[15:1], ~a[0], q});
            ptr_load_in <= p;
            ptr_load_en_in <= 1'b1;
            temp_reg_one_in <= ~r;
            k <= r;
            circ_buffer_start_in <= {r[7:0], r[15:8]};
            circ_enable_in <= r[3];
            dbl_in <= r[0];
            slow <= r[1];
            @(posedge clk_sys_in);
            ptr_load_en_in <= 1'b0;
            req_valid_in <= 1'b1;
            mode_in <= apg_pkg::apg_mode_t'(m);
            @(posedge clk_sys_in);
            req_valid_in <= 1'b0;
            for (int n = 0; n < 60 && done_out !== 1'b1; n++)
                @(posedge clk_sys_in);
        end
    endtask
    always @(posedge clk_sys_in)
        if (done_out === 1'b1 && exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            chk(23'(pair_first_out), 23'(e[54:39]));
            if (e[55])
                chk(23'(pair_second_out), 23'(e[38:23]));
            chk(ext_aux_pointer_out, e[22:0]);
        end
        else if (done_out === 1'b1)
            chk(23'h00_0001, 23'h00_0000);
    initial
    begin
        repeat (6) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        go(2'h0, 23'h00_0000);
        go(2'h2, 23'h7f_ffff);
        $display("test wrap done");
        for (int i = 0; i < 12; i++)
        begin
            go(2'(i % 3), {r[6:0], r});
            $display("test %0d done", i);
        end
        mode_in <= apg_pkg::APG_MODE_NONE;
        req_valid_in <= 1'b1;
        @(posedge clk_sys_in);
        req_valid_in <= 1'b0;
        @(posedge clk_sys_in);
        chk(23'(busy_out), 23'h00_0000);
        repeat (3) @(posedge clk_sys_in);
        chk(23'(exp_q.size()), 23'h00_0000);
        $display("test idle done");
        test_done;
    end
    initial
    begin
        repeat (4000) @(posedge clk_sys_in);
        miscompares++;
        test_done;
    end
endmodule
